// >>> hw/spbs_pkg.sv
// constants and types shared by the burst memory and its address generator.
// assumes one rising-edge clock at 20 MHz and an active-low asynchronous reset.
package spbs_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 18;
   localparam int DEPTH = 262144;
   localparam int LANES = 2;
   localparam int LANE_W = 9;
   localparam int CNT_W = 2;
   localparam int HI_W = ADDR_W - CNT_W;
   localparam int CLOCK_HZ = 20000000;
   localparam logic [1:0] WAKE_CYCLES = 2'h2;
   localparam logic [1:0] WAKE_LOAD = WAKE_CYCLES - 2'h1;
   localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
   localparam logic [LANES-1:0] MASK_ALL = 2'h3;
   localparam logic [LANES-1:0] MASK_NONE = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BURST = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE = 4'h8
   } spbs_state_type;
endpackage : spbs_pkg

// >>> hw/spbs_burst_if.sv
// carrier between the memory core and its burst address generator.
// assumes both ends sit on the same clock; no timing is carried here.
`timescale 1ns/1ps
`default_nettype none
interface spbs_burst_if;
   logic load;
   logic step;
   logic order;
   logic [spbs_pkg::CNT_W-1:0] load_bits;
   logic [spbs_pkg::CNT_W-1:0] low_bits;
   logic [spbs_pkg::CNT_W-1:0] count;
   modport ctrl (output load, output step, output order, output load_bits, input low_bits, input count);
   modport gen (input load, input step, input order, input load_bits, output low_bits, output count);
endinterface : spbs_burst_if
`default_nettype wire

// >>> hw/spbs_burst_gen.sv
// two-bit burst counter and linear or interleaved low address generation.
// assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module spbs_burst_gen (
   input wire logic i_clock, // system clock
   input wire logic i_rst_b, // asynchronous reset, active low
   spbs_burst_if.gen bif // control from the memory core
);
   typedef struct packed {
      logic [spbs_pkg::CNT_W-1:0] cnt_r;
      logic [spbs_pkg::CNT_W-1:0] start_r;
   } spbs_gen_state_type;

   spbs_gen_state_type s;
   spbs_gen_state_type s_nxt;

   always_comb begin
      s_nxt = s;
      if (bif.load) begin
         s_nxt.cnt_r = spbs_pkg::CNT_RESET;
         s_nxt.start_r = bif.load_bits;
      end else if (bif.step) begin
         s_nxt.cnt_r = s.cnt_r + spbs_pkg::CNT_STEP;
      end
   end

   // low bits for the access of this very edge, advance included
   always_comb begin
      if (bif.order) begin
         bif.low_bits = s_nxt.start_r ^ s_nxt.cnt_r;
      end else begin
         bif.low_bits = s_nxt.start_r + s_nxt.cnt_r;
      end
   end

   assign bif.count = s.cnt_r;

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
      end else begin
         s <= s_nxt;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   sequence s_load_then_step(logic ord);
      (bif.load && bif.order == ord) ##1 (bif.step && !bif.load && bif.order == ord);
   endsequence

   property p_linear_step;
      s_load_then_step(1'b0) |-> bif.low_bits == $past(bif.load_bits) + spbs_pkg::CNT_STEP;
   endproperty
   a_linear_step: assert property (p_linear_step) else $error("linear burst step wrong");

   property p_interleave_step;
      s_load_then_step(1'b1) |-> bif.low_bits == ($past(bif.load_bits) ^ spbs_pkg::CNT_STEP);
   endproperty
   a_interleave_step: assert property (p_interleave_step) else $error("interleaved burst step wrong");

   property p_counter_wrap;
      (bif.step && !bif.load)[*4] |=> bif.count == $past(bif.count, 4);
   endproperty
   a_counter_wrap: assert property (p_counter_wrap) else $error("burst counter did not wrap");
endmodule : spbs_burst_gen
`default_nettype wire

// >>> hw/spbs_sram.sv
// synchronous two-stage pipelined burst memory, 256K words of 18 bits.
// assumes address and control pins are timed to i_clock; sleep pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module spbs_sram (
   input wire logic i_clock, // 20 MHz clock
   input wire logic i_rst_b, // asynchronous reset, active low
   input wire logic [17:0] i_address, // word address
   input wire logic i_processor_address_strobe_b, // processor start, active low
   input wire logic i_controller_address_strobe_b, // controller start, active low
   input wire logic i_burst_advance_strobe_b, // burst advance, active low
   input wire logic i_primary_chip_select_b, // chip select 1, active low
   input wire logic i_chip_select2, // chip select 2, active high
   input wire logic i_chip_select3_b, // chip select 3, active low
   input wire logic i_global_write_strobe_b, // full-width write, active low
   input wire logic i_byte_write_gate_b, // lane write gate, active low
   input wire logic [1:0] i_lane_write_strobe_b, // per-lane write, active low
   input wire logic i_output_enable_b, // output drive enable, active low
   input wire logic i_burst_order_select, // 0 linear, 1 interleaved
   input wire logic i_sleep_request, // power-down request, active high
   input wire logic [17:0] i_dq_in, // data pin input
   output logic [17:0] o_dq, // data pin output
   output logic o_dq_oe_b, // data pin drive, low while driving
   output logic o_power_down // in power-down or waking
);
   typedef struct packed {
      spbs_pkg::spbs_state_type st_r;
      logic [spbs_pkg::HI_W-1:0] hi_r;
      logic rd_r;
      logic [spbs_pkg::ADDR_W-1:0] acc_r;
      logic dv1_r;
      logic [spbs_pkg::DATA_W-1:0] dout1_r;
      logic [spbs_pkg::DATA_W-1:0] dq_r;
      logic drive_r;
      logic wr_pend_r;
      logic [spbs_pkg::ADDR_W-1:0] wr_addr_r;
      logic [spbs_pkg::LANES-1:0] wr_mask_r;
      logic [spbs_pkg::DATA_W-1:0] din_r;
      logic zz1_r;
      logic zz2_r;
      logic zz3_r;
      logic [1:0] wake_r;
      logic pd_r;
   } spbs_core_state_type;

   spbs_core_state_type s;
   spbs_core_state_type s_nxt;
   logic [spbs_pkg::DATA_W-1:0] mem_r [spbs_pkg::DEPTH];
   spbs_burst_if bif ();

   logic selected;
   logic processor_address_strobe_go;
   logic controller_address_strobe_go;
   logic wr_go;
   logic desel;
   logic acc;
   logic zz_on;
   logic zz_off;
   logic [spbs_pkg::LANES-1:0] mask;
   logic [spbs_pkg::HI_W-1:0] hi_use;

   function automatic logic [spbs_pkg::LANES-1:0] lane_mask(
      input logic gw_b,
      input logic bw_b,
      input logic [spbs_pkg::LANES-1:0] we_b
   );
      if (!gw_b) begin
         lane_mask = spbs_pkg::MASK_ALL;
      end else if (!bw_b) begin
         lane_mask = ~we_b;
      end else begin
         lane_mask = spbs_pkg::MASK_NONE;
      end
   endfunction : lane_mask

   spbs_burst_gen u_burst_gen (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .bif (bif.gen)
   );

   always_comb begin
      selected = !i_primary_chip_select_b && i_chip_select2 && !i_chip_select3_b;
      processor_address_strobe_go = !i_processor_address_strobe_b && !i_primary_chip_select_b;
      controller_address_strobe_go = !i_controller_address_strobe_b && (i_processor_address_strobe_b || i_primary_chip_select_b);
      mask = lane_mask(i_global_write_strobe_b, i_byte_write_gate_b, i_lane_write_strobe_b);
      zz_on = s.zz2_r && s.zz3_r;
      zz_off = !s.zz2_r && !s.zz3_r;
   end

   always_comb begin
      s_nxt = s;
      wr_go = 1'b0;
      desel = 1'b0;
      acc = 1'b0;
      hi_use = s.hi_r;
      bif.load = 1'b0;
      bif.step = 1'b0;
      bif.order = i_burst_order_select;
      bif.load_bits = i_address[1:0];
      s_nxt.zz1_r = i_sleep_request;
      s_nxt.zz2_r = s.zz1_r;
      s_nxt.zz3_r = s.zz2_r;
      case (s.st_r)
         spbs_pkg::ST_IDLE, spbs_pkg::ST_BURST: begin
            if (zz_on) begin
               s_nxt.st_r = spbs_pkg::ST_SLEEP;
            end else if (i_sleep_request) begin
               // raw pin freezes access at once; synchronised copy moves the state
               s_nxt.st_r = s.st_r;
            end else if (processor_address_strobe_go || controller_address_strobe_go) begin
               if (selected) begin
                  bif.load = 1'b1;
                  hi_use = i_address[17:2];
                  s_nxt.hi_r = i_address[17:2];
                  s_nxt.st_r = spbs_pkg::ST_BURST;
                  acc = 1'b1;
                  wr_go = !processor_address_strobe_go && (mask != spbs_pkg::MASK_NONE);
               end else begin
                  desel = 1'b1;
                  s_nxt.st_r = spbs_pkg::ST_IDLE;
               end
            end else if (s.st_r == spbs_pkg::ST_BURST) begin
               bif.step = !i_burst_advance_strobe_b;
               acc = 1'b1;
               wr_go = (mask != spbs_pkg::MASK_NONE);
            end
         end
         spbs_pkg::ST_SLEEP: begin
            if (zz_off) begin
               s_nxt.st_r = spbs_pkg::ST_WAKE;
               s_nxt.wake_r = spbs_pkg::WAKE_LOAD;
            end
         end
         spbs_pkg::ST_WAKE: begin
            if (zz_on) begin
               s_nxt.st_r = spbs_pkg::ST_SLEEP;
            end else if (s.wake_r == 2'h0) begin
               s_nxt.st_r = spbs_pkg::ST_IDLE;
            end else begin
               s_nxt.wake_r = s.wake_r - 2'h1;
            end
         end
         default: begin
            s_nxt.st_r = spbs_pkg::ST_IDLE;
         end
      endcase
      s_nxt.rd_r = acc && !wr_go;
      if (acc) begin
         s_nxt.acc_r = {hi_use, bif.low_bits};
      end
      s_nxt.wr_pend_r = wr_go;
      if (wr_go) begin
         s_nxt.wr_addr_r = {hi_use, bif.low_bits};
         s_nxt.wr_mask_r = mask;
         s_nxt.din_r = i_dq_in;
      end
      s_nxt.dv1_r = s.rd_r;
      if (s.rd_r) begin
         s_nxt.dout1_r = mem_r[s.acc_r];
      end
      if (s.dv1_r) begin
         s_nxt.dq_r = s.dout1_r;
      end
      // drivers released one edge after deselect or a write, enabled two edges after a read start
      s_nxt.drive_r = s.dv1_r && !wr_go && !desel && (s_nxt.st_r != spbs_pkg::ST_SLEEP);
      s_nxt.pd_r = (s_nxt.st_r == spbs_pkg::ST_SLEEP) || (s_nxt.st_r == spbs_pkg::ST_WAKE);
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '{st_r: spbs_pkg::ST_IDLE, acc_r: spbs_pkg::ADDR_RESET, dout1_r: spbs_pkg::DATA_RESET,
                dq_r: spbs_pkg::DATA_RESET, default: '0};
      end else begin
         s <= s_nxt;
      end
   end

   // array has no reset: contents survive reset and sleep alike
   always_ff @(posedge i_clock) begin
      if (s.wr_pend_r) begin
         for (int lane = 0; lane < spbs_pkg::LANES; lane++) begin
            if (s.wr_mask_r[lane]) begin
               mem_r[s.wr_addr_r][lane*spbs_pkg::LANE_W +: spbs_pkg::LANE_W] <=
                  s.din_r[lane*spbs_pkg::LANE_W +: spbs_pkg::LANE_W];
            end
         end
      end
   end

   assign o_dq = s.dq_r;
   // gated after the flop on purpose: drive must follow the pins without a clock
   assign o_dq_oe_b = !(s.drive_r && !i_output_enable_b && !i_sleep_request);
   assign o_power_down = s.pd_r;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   property p_global_write;
      wr_go && !i_global_write_strobe_b |=> s.wr_pend_r && s.wr_mask_r == spbs_pkg::MASK_ALL;
   endproperty
   a_global_write: assert property (p_global_write) else $error("global write not full width");

   property p_lane_write;
      wr_go && i_global_write_strobe_b |=> s.wr_mask_r == ~$past(i_lane_write_strobe_b);
   endproperty
   a_lane_write: assert property (p_lane_write) else $error("lane write mask wrong");

   property p_cs1_blocks;
      (s.st_r == spbs_pkg::ST_IDLE) && i_primary_chip_select_b && !i_processor_address_strobe_b &&
         i_controller_address_strobe_b && !zz_on |=> s.st_r == spbs_pkg::ST_IDLE && !s.rd_r;
   endproperty
   a_cs1_blocks: assert property (p_cs1_blocks) else $error("processor strobe not blocked");

   property p_hold_count;
      (s.st_r == spbs_pkg::ST_BURST) && !processor_address_strobe_go && !controller_address_strobe_go && !i_sleep_request && !zz_on &&
         i_burst_advance_strobe_b |=> $stable(bif.count);
   endproperty
   a_hold_count: assert property (p_hold_count) else $error("counter moved without advance");

   property p_processor_address_strobe_restart;
      processor_address_strobe_go && selected && !s.pd_r && !i_sleep_request && !zz_on && !i_burst_advance_strobe_b |=>
         bif.count == spbs_pkg::CNT_RESET && !s.wr_pend_r;
   endproperty
   a_processor_address_strobe_restart: assert property (p_processor_address_strobe_restart) else $error("advance or write taken on start");

   property p_enable_delay;
      $rose(s.drive_r) |-> $past(s.rd_r, 2);
   endproperty
   a_enable_delay: assert property (p_enable_delay) else $error("outputs enabled too early");

   property p_disable_one;
      desel |=> !s.drive_r && o_dq_oe_b;
   endproperty
   a_disable_one: assert property (p_disable_one) else $error("outputs not off one cycle after deselect");

   sequence s_read_start;
      s.rd_r && !wr_go && !desel && !zz_on;
   endsequence

   property p_read_pipe;
      s_read_start ##1 (!wr_go && !desel && !zz_on) |=> s.drive_r && o_dq == $past(s.dout1_r);
   endproperty
   a_read_pipe: assert property (p_read_pipe) else $error("read data not out two edges on");

   property p_async_oe;
      i_output_enable_b || i_sleep_request |-> o_dq_oe_b;
   endproperty
   a_async_oe: assert property (p_async_oe) else $error("drivers on while disabled");

   sequence s_wake_enter;
      $past(s.st_r) == spbs_pkg::ST_SLEEP && s.st_r == spbs_pkg::ST_WAKE;
   endsequence

   property p_wake_time;
      s_wake_enter |=> (s.st_r != spbs_pkg::ST_IDLE && s.st_r != spbs_pkg::ST_BURST && !s.rd_r);
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("woke in under two cycles");

   property p_sleep_no_write;
      (s.st_r == spbs_pkg::ST_SLEEP) || i_sleep_request |-> !wr_go && !acc;
   endproperty
   a_sleep_no_write: assert property (p_sleep_no_write) else $error("access while asleep");
endmodule : spbs_sram
`default_nettype wire

// >>> testbench/spbs_master.sv
// bus master model: drives the address, strobe, write and static pins of the burst memory.
// assumes the bench calls cyc once per clock, starting just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module spbs_master (
   input wire logic i_clock, // bus clock
   output logic [17:0] o_address, // word address
   output logic o_proc_strobe_b, // processor start, low active
   output logic o_ctrl_strobe_b, // controller start, low active
   output logic o_advance_b, // burst advance, low active
   output logic o_select_b, // primary select, low active
   output logic o_global_wr_b, // full-width write, low active
   output logic o_gate_b, // lane write gate, low active
   output logic [1:0] o_lane_b, // lane write strobes, low active
   output logic [17:0] o_data, // write data
   output logic o_oe_b, // output enable, low active
   output logic o_order, // burst order select
   output logic o_sleep // sleep request
);
   initial begin
      {o_select_b, o_proc_strobe_b, o_ctrl_strobe_b, o_advance_b, o_global_wr_b, o_gate_b, o_lane_b} = 8'hff;
      {o_oe_b, o_order, o_sleep, o_address, o_data} = {3'h4, 36'h0};
   end

   task automatic cyc(input logic sel_b, input logic proc_b, input logic ctrl_b, input logic adv_b,
                      input logic [17:0] a, input logic gw_b, input logic gate_b, input logic [1:0] lane_b,
                      input logic [17:0] d);
      o_select_b = sel_b;
      o_proc_strobe_b = proc_b || !ctrl_b;
      o_ctrl_strobe_b = ctrl_b;
      o_advance_b = adv_b;
      o_address = a;
      o_global_wr_b = gw_b;
      o_gate_b = gate_b;
      o_lane_b = lane_b;
      // data line not written this cycle toggles, so a stale value never looks valid
      o_data = (!gw_b || (!gate_b && lane_b != 2'h3)) ? d : ~o_data;
      @(posedge i_clock);
      #1;
   endtask : cyc

   task automatic pins(input logic oe_b, input logic order, input logic sleep);
      o_oe_b = oe_b;
      o_order = order;
      o_sleep = sleep;
   endtask : pins
endmodule : spbs_master
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the pipelined burst memory.
// assumes the master model drives all bus pins; two extra selects are tied active.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock;
   logic rst_b;
   int err_total;
   int n_tests;
   int cycle_n;
   logic [17:0] mem [logic [17:0]];
   wire logic [17:0] addr, data, o_dq;
   wire logic ps_b, cs_b, adv_b, sel_b, gw_b, gate_b, oe_b, order, sleep;
   wire logic [1:0] lane_b;
   logic o_dq_oe_b;
   logic o_power_down;

   spbs_master u_master (.i_clock(clock), .o_address(addr), .o_proc_strobe_b(ps_b), .o_ctrl_strobe_b(cs_b),
      .o_advance_b(adv_b), .o_select_b(sel_b), .o_global_wr_b(gw_b), .o_gate_b(gate_b), .o_lane_b(lane_b),
      .o_data(data), .o_oe_b(oe_b), .o_order(order), .o_sleep(sleep));

   spbs_sram u_spbs_sram (.i_clock(clock), .i_rst_b(rst_b), .i_address(addr), .i_processor_address_strobe_b(ps_b),
      .i_controller_address_strobe_b(cs_b), .i_burst_advance_strobe_b(adv_b), .i_primary_chip_select_b(sel_b),
      .i_chip_select2(1'b1), .i_chip_select3_b(1'b0), .i_global_write_strobe_b(gw_b), .i_byte_write_gate_b(gate_b),
      .i_lane_write_strobe_b(lane_b), .i_output_enable_b(oe_b), .i_burst_order_select(order),
      .i_sleep_request(sleep), .i_dq_in(data), .o_dq(o_dq), .o_dq_oe_b(o_dq_oe_b), .o_power_down(o_power_down));

   always #25 clock = ~clock;

   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic idle;
      u_master.cyc(1'b0, 1'b1, 1'b1, 1'b1, 18'h00000, 1'b1, 1'b1, 2'h3, 18'h0);
   endtask : idle

   task automatic t_write(input logic [17:0] a, input logic g, input logic gt, input logic [1:0] ln,
                          input logic [17:0] d);
      u_master.cyc(1'b0, 1'b1, 1'b0, 1'b1, a, g, gt, ln, d);
      if (!g) mem[a] = d;
      else if (!gt) begin
         if (!ln[0]) mem[a][8:0] = d[8:0];
         if (!ln[1]) mem[a][17:9] = d[17:9];
      end
      idle();
      idle();
   endtask : t_write

   // adv[0] is the start edge and must be ignored; the rest step or wait
   task automatic t_burst(input logic [17:0] a, input logic ord, input logic [4:0] burst_advance_strobe);
      logic [17:0] ex [5];
      logic [1:0] c;
      c = 2'h0;
      for (int i = 0; i < 5; i++) begin
         if (i > 0 && !burst_advance_strobe[i]) c = c + 2'h1;
         ex[i] = mem[{a[17:2], ord ? (a[1:0] ^ c) : (a[1:0] + c)}];
      end
      u_master.pins(1'b0, ord, 1'b0);
      u_master.cyc(1'b1, 1'b1, 1'b0, 1'b1, a, 1'b1, 1'b1, 2'h3, 18'h0);
      for (int i = 0; i < 8; i++) begin
         // address changes after the start edge, so only the captured copy can be used
         u_master.cyc(i == 7, i != 0, i != 7, i < 5 ? burst_advance_strobe[i] : 1'b1, i == 0 ? a : ~a, i != 0, i != 0,
                      {2{i != 0}}, 18'h0);
         if (i == 1) chk("drive_early", 18'h1, {17'h0, o_dq_oe_b});
         if (i >= 2 && i < 7) begin
            chk("read_data", ex[i-2], o_dq);
            chk("drive_on", 18'h0, {17'h0, o_dq_oe_b});
         end
         if (i == 7) chk("drive_off", 18'h1, {17'h0, o_dq_oe_b});
      end
      $display("burst test done");
   endtask : t_burst

   task automatic t_block;
      u_master.cyc(1'b1, 1'b0, 1'b1, 1'b1, 18'h3fffc, 1'b1, 1'b1, 2'h3, 18'h0);
      for (int i = 0; i < 3; i++) begin
         idle();
         chk("blocked_drive", 18'h1, {17'h0, o_dq_oe_b});
      end
      $display("blocked strobe test done");
   endtask : t_block

   task automatic t_async;
      u_master.cyc(1'b0, 1'b0, 1'b1, 1'b1, 18'h3fffc, 1'b1, 1'b1, 2'h3, 18'h0);
      repeat (3) idle();
      u_master.pins(1'b1, 1'b0, 1'b0);
      #1;
      chk("oe_off", 18'h1, {17'h0, o_dq_oe_b});
      u_master.pins(1'b0, 1'b0, 1'b0);
      #1;
      chk("oe_on", 18'h0, {17'h0, o_dq_oe_b});
      u_master.pins(1'b0, 1'b0, 1'b1);
      #1;
      chk("sleep_freeze", 18'h1, {17'h0, o_dq_oe_b});
      repeat (5) idle();
      chk("sleep_state", 18'h1, {17'h0, o_power_down});
      u_master.pins(1'b0, 1'b0, 1'b0);
      repeat (2) idle();
      chk("wake_hold", 18'h1, {17'h0, o_power_down});
      repeat (6) idle();
      chk("wake_done", 18'h0, {17'h0, o_power_down});
      $display("async pin test done");
   endtask : t_async

   always @(posedge clock) begin
      cycle_n++;
      if (cycle_n == 3000) begin
         err_total++;
         final_report();
      end
   end

   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      err_total = 0;
      n_tests = 0;
      cycle_n = 0;
      repeat (8) @(posedge clock);
      #1;
      chk("reset_dq", 18'h0, o_dq);
      chk("reset_oe", 18'h1, {17'h0, o_dq_oe_b});
      chk("reset_pd", 18'h0, {17'h0, o_power_down});
      repeat (8) @(posedge clock);
      #1;
      rst_b = 1'b1;
      for (int j = 0; j < 4; j++) t_write(18'h3fffc + 18'(j), 1'b0, 1'b1, 2'h3, 18'h01111 * 18'(j + 1));
      t_write(18'h3fffd, 1'b1, 1'b0, 2'h2, 18'h3ffff);
      t_write(18'h3fffc, 1'b1, 1'b0, 2'h1, 18'h00000);
      t_write(18'h3fffe, 1'b1, 1'b1, 2'h0, 18'h3ffff);
      t_write(18'h3ffff, 1'b0, 1'b1, 2'h3, 18'h2aaaa);
      t_burst(18'h3fffe, 1'b0, 5'h00);
      t_burst(18'h3fffd, 1'b1, 5'h14);
      t_burst(18'h3ffff, 1'b1, 5'h00);
      t_block();
      t_async();
      t_burst(18'h3fffc, 1'b0, 5'h0a);
      final_report();
   end
endmodule : testbench
`default_nettype wire
